/* File: tmu_channel.sv */
`timescale 1ns/1ps
// One 16-bit timer channel: clock selection, gating, compare and reload.
module tmu_channel #(
  parameter int WIDTH = 16,
  parameter bit HAS_PINS = 1'b1
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire tmu_pkg::tmu_ctrl_type ctrl,
  input wire logic [WIDTH-1:0] compare_a,
  input wire logic [WIDTH-1:0] compare_b,
  input wire logic internal_tick,
  input wire logic prescale_tick,
  input wire logic pin_level,
  input wire logic pin_rise,
  input wire logic load,
  input wire logic [WIDTH-1:0] load_value,
  output logic [WIDTH-1:0] count,
  output logic which,
  output logic hit,
  output logic halt,
  output logic out_pin
);

  logic [1:0] ext_div;
  logic pulse_low;
  logic [WIDTH-1:0] next_count;
  logic [1:0] next_ext_div;
  logic next_which;
  logic next_hit;
  logic next_halt;
  logic next_pulse_low;
  logic next_out_pin;
  logic use_ext;
  logic dual;
  logic tick;
  logic gate_ok;
  logic retrig;
  logic step;
  logic [WIDTH-1:0] limit;

  // Clock source, gating and the active compare value.
  assign use_ext = HAS_PINS && ctrl.outside_clock_select;
  assign dual = HAS_PINS && ctrl.dual_compare_mode;
  assign tick = use_ext ? (pin_rise && ext_div == tmu_pkg::STEP_LAST)
    : ((HAS_PINS && ctrl.prescale) ? prescale_tick : internal_tick);
  assign gate_ok = !HAS_PINS || use_ext || ctrl.retrigger_select || pin_level;
  assign retrig = HAS_PINS && !ctrl.outside_clock_select && ctrl.retrigger_select && pin_rise;
  assign step = ctrl.en && gate_ok && tick;
  assign limit = (dual && which) ? compare_b : compare_a;

  // Next count, compare-register select, events and output level.
  always_comb
  begin
    next_count = count;
    next_ext_div = ext_div;
    next_which = which;
    next_hit = 1'b0;
    next_halt = 1'b0;
    next_pulse_low = pulse_low;
    if (use_ext && pin_rise)
    begin
      next_ext_div = ext_div + 2'h1;
    end
    if (tick)
    begin
      next_pulse_low = 1'b0;
    end
    if (load)
    begin
      next_count = load_value;
    end
    else if (retrig)
    begin
      next_count = '0;
    end
    else if (step)
    begin
      if (count == limit)
      begin
        next_count = '0;
        next_hit = 1'b1;
        next_halt = !ctrl.free_running;
        next_pulse_low = !dual;
        next_which = dual ? !which : 1'b0;
      end
      else
      begin
        next_count = count + 1'b1;
      end
    end
    if (!dual)
    begin
      next_which = 1'b0;
    end
    next_out_pin = dual ? !next_which : !next_pulse_low;
  end

  // Registers of the channel.
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      count <= tmu_pkg::COUNT_RESET;
      ext_div <= 2'h0;
      which <= 1'b0;
      hit <= 1'b0;
      halt <= 1'b0;
      pulse_low <= 1'b0;
      out_pin <= 1'b1;
    end
    else
    begin
      count <= next_count;
      ext_div <= next_ext_div;
      which <= next_which;
      hit <= next_hit;
      halt <= next_halt;
      pulse_low <= next_pulse_low;
      out_pin <= next_out_pin;
    end
  end

endmodule : tmu_channel

/* File: tmu_pins.sv */
`timescale 1ns/1ps
// Outside event source that drives the two timer input pins.
module tmu_pins (
  input wire logic sys_clk,
  output logic [1:0] in_pin
);
  initial in_pin = 2'h0;
  // Holds one pin at a level.
  task automatic set(input int idx, input logic v);
    in_pin[idx] <= v;
  endtask : set
  // Sends rising edges with each level held four clocks so the filter sees them.
  task automatic pulses(input int idx, input int n);
    repeat (n)
    begin
      in_pin[idx] <= 1'b0;
      repeat (4) @(posedge sys_clk);
      in_pin[idx] <= 1'b1;
      repeat (4) @(posedge sys_clk);
    end
  endtask : pulses
endmodule : tmu_pins

/* File: tmu_pkg.sv */
package tmu_pkg;

  // Register indices; the byte address of each register is four times its index.
  localparam logic [7:0] T0_COUNT_IDX = 8'h50;
  localparam logic [7:0] T0_CMPA_IDX = 8'h52;
  localparam logic [7:0] T0_CMPB_IDX = 8'h54;
  localparam logic [7:0] T0_CTRL_IDX = 8'h56;
  localparam logic [7:0] T1_COUNT_IDX = 8'h58;
  localparam logic [7:0] T1_CMPA_IDX = 8'h5a;
  localparam logic [7:0] T1_CMPB_IDX = 8'h5c;
  localparam logic [7:0] T1_CTRL_IDX = 8'h5e;
  localparam logic [7:0] T2_COUNT_IDX = 8'h60;
  localparam logic [7:0] T2_CMPA_IDX = 8'h62;
  localparam logic [7:0] T2_CTRL_IDX = 8'h66;
  localparam logic [7:0] DMA_REQ_EN_IDX = 8'h68;

  // Bit positions inside a control word.
  localparam int EN_BIT = 15;
  localparam int MASK_BIT = 14;
  localparam int INT_BIT = 13;
  localparam int WHICH_BIT = 12;
  localparam int MC_BIT = 5;
  localparam int RTG_BIT = 4;
  localparam int PRE_BIT = 3;
  localparam int EXT_BIT = 2;
  localparam int ALT_BIT = 1;
  localparam int FREE_RUNNING_BIT = 0;

  // Reset values.
  localparam logic [15:0] CTRL_RESET = 16'h0000;
  localparam logic [15:0] COUNT_RESET = 16'h0000;
  localparam logic [15:0] CMP_RESET = 16'h0000;
  localparam logic [1:0] DMA_EN_RESET = 2'h0;

  // Clocks (internal or external) per count step.
  localparam int CLOCKS_PER_STEP = 4;
  localparam logic [1:0] STEP_LAST = 2'(CLOCKS_PER_STEP - 1);

  // Stored control fields of one timer.
  typedef struct packed {
    logic en;
    logic int_en;
    logic mc;
    logic retrigger_select;
    logic prescale;
    logic outside_clock_select;
    logic dual_compare_mode;
    logic free_running;
  } tmu_ctrl_type;

  // State reported by one timer channel.
  typedef struct packed {
    logic [15:0] count;
    logic which;
    logic hit;
    logic halt;
    logic out_pin;
  } tmu_status_type;

endpackage : tmu_pkg

/* File: tmu_top.sv */
// Implementation choice: the Avalon-MM register port.
`timescale 1ns/1ps
module tmu_top (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic timer0_input_pin,
  input wire logic timer1_input_pin,
  output logic timer0_output_pin,
  output logic timer1_output_pin,
  output logic [2:0] timer_irq,
  output logic [1:0] dma_timer_request
);

  localparam logic [7:0] CTRL_IDX [3] = '{tmu_pkg::T0_CTRL_IDX, tmu_pkg::T1_CTRL_IDX,
    tmu_pkg::T2_CTRL_IDX};
  localparam logic [7:0] COUNT_IDX [3] = '{tmu_pkg::T0_COUNT_IDX, tmu_pkg::T1_COUNT_IDX,
    tmu_pkg::T2_COUNT_IDX};
  localparam logic [7:0] CMPA_IDX [3] = '{tmu_pkg::T0_CMPA_IDX, tmu_pkg::T1_CMPA_IDX,
    tmu_pkg::T2_CMPA_IDX};
  localparam logic [7:0] CMPB_IDX [2] = '{tmu_pkg::T0_CMPB_IDX, tmu_pkg::T1_CMPB_IDX};

  // Forms the readable control word; the mask bit is never stored.
  function automatic logic [15:0] ctrl_word(input tmu_pkg::tmu_ctrl_type c,
    input logic which, input logic has_pins);
    logic [15:0] w;
    w = 16'h0000;
    w[tmu_pkg::EN_BIT] = c.en;
    w[tmu_pkg::MASK_BIT] = 1'b0;
    w[tmu_pkg::INT_BIT] = c.int_en;
    w[tmu_pkg::WHICH_BIT] = has_pins & which;
    w[tmu_pkg::MC_BIT] = c.mc;
    w[tmu_pkg::FREE_RUNNING_BIT] = c.free_running;
    if (has_pins)
    begin
      w[tmu_pkg::RTG_BIT] = c.retrigger_select;
      w[tmu_pkg::PRE_BIT] = c.prescale;
      w[tmu_pkg::EXT_BIT] = c.outside_clock_select;
      w[tmu_pkg::ALT_BIT] = c.dual_compare_mode;
    end
    return w;
  endfunction : ctrl_word

  // Tells whether a bus cycle addresses a given register index.
  function automatic logic hits_index(input logic [7:0] addr, input logic [7:0] idx);
    return addr == idx;
  endfunction : hits_index

  tmu_pkg::tmu_ctrl_type ctrl [3];
  tmu_pkg::tmu_ctrl_type next_ctrl [3];
  logic [15:0] cmp_a [3];
  logic [15:0] next_cmp_a [3];
  logic [15:0] cmp_b [2];
  logic [15:0] next_cmp_b [2];
  logic [1:0] dma_en;
  logic [1:0] next_dma_en;
  tmu_pkg::tmu_status_type status [3];
  logic [2:0] load;

  logic ack;
  logic next_ack;
  logic [31:0] next_readdata;
  logic wr_take;
  logic [2:0] next_irq;
  logic [1:0] next_dma_req;

  logic [1:0] prescaler;
  logic [1:0] next_prescaler;
  logic internal_tick;

  logic [2:0] pin_sync [2];
  logic [2:0] next_pin_sync [2];
  logic [1:0] pin_level;
  logic [1:0] next_pin_level;
  logic [1:0] pin_rise;
  logic [1:0] next_pin_rise;
  logic [1:0] raw_pin;

  assign raw_pin = {timer1_input_pin, timer0_input_pin};

  // Bus handshake: the first request cycle waits, the second completes.
  assign avs_waitrequest = (avs_read || avs_write) && !ack;
  assign wr_take = avs_write && ack;
  assign next_ack = (avs_read || avs_write) && !ack;

  // Shared divide-by-four stepping of the internal processor clock.
  assign next_prescaler = prescaler + 2'h1;
  assign internal_tick = prescaler == tmu_pkg::STEP_LAST;

  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      prescaler <= 2'h0;
    end
    else
    begin
      prescaler <= next_prescaler;
    end
  end

  // Input pins pass three flops; a level counts once the last two agree.
  always_comb
  begin
    for (int p = 0; p < 2; p++)
    begin
      next_pin_sync[p] = {pin_sync[p][1:0], raw_pin[p]};
      next_pin_level[p] = pin_level[p];
      next_pin_rise[p] = 1'b0;
      if (pin_sync[p][1] == pin_sync[p][2])
      begin
        next_pin_level[p] = pin_sync[p][2];
        next_pin_rise[p] = pin_sync[p][2] && !pin_level[p];
      end
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      pin_sync[0] <= 3'h0;
      pin_sync[1] <= 3'h0;
      pin_level <= 2'h0;
      pin_rise <= 2'h0;
    end
    else
    begin
      pin_sync[0] <= next_pin_sync[0];
      pin_sync[1] <= next_pin_sync[1];
      pin_level <= next_pin_level;
      pin_rise <= next_pin_rise;
    end
  end

  // Timer channels; timers 0 and 1 own pins, timer 2 has none.
  generate
    for (genvar t = 0; t < 3; t++)
    begin : g_timer
      assign load[t] = wr_take && hits_index(avs_address, COUNT_IDX[t]);
      tmu_channel #(
        .WIDTH(16),
        .HAS_PINS(t < 2)
      ) u_channel (
        .sys_clk(sys_clk),
        .rst(rst),
        .ctrl(ctrl[t]),
        .compare_a(cmp_a[t]),
        .compare_b((t < 2) ? cmp_b[t % 2] : tmu_pkg::CMP_RESET),
        .internal_tick(internal_tick),
        .prescale_tick(status[2].hit),
        .pin_level((t < 2) ? pin_level[t % 2] : 1'b1),
        .pin_rise((t < 2) ? pin_rise[t % 2] : 1'b0),
        .load(load[t]),
        .load_value(avs_writedata[15:0]),
        .count(status[t].count),
        .which(status[t].which),
        .hit(status[t].hit),
        .halt(status[t].halt),
        .out_pin(status[t].out_pin)
      );
    end
  endgenerate

  // Register file updates: software writes, hardware flags and halts.
  always_comb
  begin
    for (int t = 0; t < 3; t++)
    begin
      next_ctrl[t] = ctrl[t];
      next_cmp_a[t] = cmp_a[t];
      if (status[t].halt)
      begin
        next_ctrl[t].en = 1'b0;
      end
      if (wr_take && hits_index(avs_address, CTRL_IDX[t]))
      begin
        if (avs_writedata[tmu_pkg::MASK_BIT])
        begin
          next_ctrl[t].en = avs_writedata[tmu_pkg::EN_BIT];
        end
        next_ctrl[t].int_en = avs_writedata[tmu_pkg::INT_BIT];
        next_ctrl[t].mc = avs_writedata[tmu_pkg::MC_BIT];
        next_ctrl[t].free_running = avs_writedata[tmu_pkg::FREE_RUNNING_BIT];
        next_ctrl[t].retrigger_select = (t < 2) && avs_writedata[tmu_pkg::RTG_BIT];
        next_ctrl[t].prescale = (t < 2) && avs_writedata[tmu_pkg::PRE_BIT];
        next_ctrl[t].outside_clock_select = (t < 2) && avs_writedata[tmu_pkg::EXT_BIT];
        next_ctrl[t].dual_compare_mode = (t < 2) && avs_writedata[tmu_pkg::ALT_BIT];
      end
      if (status[t].hit)
      begin
        next_ctrl[t].mc = 1'b1;
      end
      if (wr_take && hits_index(avs_address, CMPA_IDX[t]))
      begin
        next_cmp_a[t] = avs_writedata[15:0];
      end
    end
    for (int t = 0; t < 2; t++)
    begin
      next_cmp_b[t] = cmp_b[t];
      if (wr_take && hits_index(avs_address, CMPB_IDX[t]))
      begin
        next_cmp_b[t] = avs_writedata[15:0];
      end
    end
    next_dma_en = dma_en;
    if (wr_take && hits_index(avs_address, tmu_pkg::DMA_REQ_EN_IDX))
    begin
      next_dma_en = avs_writedata[1:0];
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      for (int t = 0; t < 3; t++)
      begin
        ctrl[t] <= tmu_pkg::tmu_ctrl_type'(8'h00);
        cmp_a[t] <= tmu_pkg::CMP_RESET;
      end
      cmp_b[0] <= tmu_pkg::CMP_RESET;
      cmp_b[1] <= tmu_pkg::CMP_RESET;
      dma_en <= tmu_pkg::DMA_EN_RESET;
    end
    else
    begin
      for (int t = 0; t < 3; t++)
      begin
        ctrl[t] <= next_ctrl[t];
        cmp_a[t] <= next_cmp_a[t];
      end
      cmp_b[0] <= next_cmp_b[0];
      cmp_b[1] <= next_cmp_b[1];
      dma_en <= next_dma_en;
    end
  end

  // Read data is captured in the waiting cycle and stands in the answer cycle.
  always_comb
  begin
    next_readdata = avs_readdata;
    if (avs_read && !ack)
    begin
      next_readdata = 32'h0000_0000;
      for (int t = 0; t < 3; t++)
      begin
        if (hits_index(avs_address, CTRL_IDX[t]))
        begin
          next_readdata[15:0] = ctrl_word(ctrl[t], status[t].which, t < 2);
        end
        if (hits_index(avs_address, COUNT_IDX[t]))
        begin
          next_readdata[15:0] = status[t].count;
        end
        if (hits_index(avs_address, CMPA_IDX[t]))
        begin
          next_readdata[15:0] = cmp_a[t];
        end
      end
      for (int t = 0; t < 2; t++)
      begin
        if (hits_index(avs_address, CMPB_IDX[t]))
        begin
          next_readdata[15:0] = cmp_b[t];
        end
      end
      if (hits_index(avs_address, tmu_pkg::DMA_REQ_EN_IDX))
      begin
        next_readdata[1:0] = dma_en;
      end
    end
  end

  // Interrupt and DMA request pulses follow each maximum by one cycle.
  always_comb
  begin
    for (int t = 0; t < 3; t++)
    begin
      next_irq[t] = status[t].hit && ctrl[t].int_en;
    end
    next_dma_req = {2{status[2].hit}} & dma_en;
  end

  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      ack <= 1'b0;
      avs_readdata <= 32'h0000_0000;
      timer_irq <= 3'h0;
      dma_timer_request <= 2'h0;
      timer0_output_pin <= 1'b1;
      timer1_output_pin <= 1'b1;
    end
    else
    begin
      ack <= next_ack;
      avs_readdata <= next_readdata;
      timer_irq <= next_irq;
      dma_timer_request <= next_dma_req;
      timer0_output_pin <= status[0].out_pin;
      timer1_output_pin <= status[1].out_pin;
    end
  end

endmodule : tmu_top

/* File: tmu_top_props.sv */
`timescale 1ns/1ps
// Watches the timer unit ports for pulse spacing, read data and pin shapes.
module tmu_top_props (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  input wire logic timer0_input_pin,
  input wire logic timer1_input_pin,
  input wire logic timer0_output_pin,
  input wire logic timer1_output_pin,
  input wire logic [2:0] timer_irq,
  input wire logic [1:0] dma_timer_request
);
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (rst);
  // A read completes at the edge where waitrequest is low.
  wire logic done_rd = avs_read && !avs_waitrequest;
  wire logic ctrl_rd = avs_address == tmu_pkg::T0_CTRL_IDX
    || avs_address == tmu_pkg::T1_CTRL_IDX || avs_address == tmu_pkg::T2_CTRL_IDX;
  property p_t0_gap;
    timer_irq[0] |=> !timer_irq[0] [*3];
  endproperty
  a_t0_gap: assert property (p_t0_gap) else $error("timer 0 requests too close");
  property p_t1_gap;
    timer_irq[1] |=> !timer_irq[1] [*3];
  endproperty
  a_t1_gap: assert property (p_t1_gap) else $error("timer 1 requests too close");
  property p_t2_gap;
    timer_irq[2] |=> !timer_irq[2] [*3];
  endproperty
  a_t2_gap: assert property (p_t2_gap) else $error("timer 2 requests too close");
  property p_dma_gap;
    dma_timer_request[0] |=> !dma_timer_request[0] [*3];
  endproperty
  a_dma_gap: assert property (p_dma_gap) else $error("dma requests too close");
  property p_upper;
    done_rd |-> avs_readdata[31:16] == 16'h0000;
  endproperty
  a_upper: assert property (p_upper) else $error("read data upper half not zero");
  property p_mask;
    done_rd && ctrl_rd |-> !avs_readdata[tmu_pkg::MASK_BIT];
  endproperty
  a_mask: assert property (p_mask) else $error("mask bit read as one");
  property p_t2_resv;
    done_rd && avs_address == tmu_pkg::T2_CTRL_IDX
      |-> avs_readdata[12:6] == 7'h00 && avs_readdata[4:1] == 4'h0;
  endproperty
  a_t2_resv: assert property (p_t2_resv) else $error("timer 2 reserved bits set");
  property p_pin0_low;
    $fell(timer0_output_pin) |=> !timer0_output_pin [*3];
  endproperty
  a_pin0_low: assert property (p_pin0_low) else $error("timer 0 pin low too short");
  property p_pin1_low;
    $fell(timer1_output_pin) |=> !timer1_output_pin [*3];
  endproperty
  a_pin1_low: assert property (p_pin1_low) else $error("timer 1 pin low too short");
  c_irq0: cover property (timer_irq[0]);
  c_dma0: cover property (dma_timer_request[0]);
  c_pin1: cover property ($fell(timer1_output_pin));
endmodule : tmu_top_props

bind tmu_top tmu_top_props u_props (.sys_clk(sys_clk), .rst(rst), .avs_address(avs_address),
  .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
  .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
  .timer0_input_pin(timer0_input_pin), .timer1_input_pin(timer1_input_pin),
  .timer0_output_pin(timer0_output_pin), .timer1_output_pin(timer1_output_pin),
  .timer_irq(timer_irq), .dma_timer_request(dma_timer_request));

/* File: tmu_top_tb.sv */
`timescale 1ns/1ps
// Self-checking bench for the three channel timer unit.
module tmu_top_tb;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] avs_address = 8'h00;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic [1:0] in_pin;
  logic [1:0] out_pin;
  logic [2:0] timer_irq;
  logic [1:0] dma_timer_request;
  logic [15:0] rd;
  logic [15:0] q1;
  int miscompares = 0;
  int comparisons = 0;
  int n;
  int n1;
  int n2;
  `define CHECK(got, exp) \
    begin \
      comparisons++; \
      if ((got) !== (exp)) \
      begin \
        miscompares++; \
        $display("mismatch at %0t: got %h expected %h", $time, (got), (exp)); \
      end \
    end
  // Clock at 250 MHz.
  always #2 sys_clk = ~sys_clk;
  tmu_top u_dut (.sys_clk(sys_clk), .rst(rst), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .timer0_input_pin(in_pin[0]), .timer1_input_pin(in_pin[1]),
    .timer0_output_pin(out_pin[0]), .timer1_output_pin(out_pin[1]),
    .timer_irq(timer_irq), .dma_timer_request(dma_timer_request));
  tmu_pins u_pins (.sys_clk(sys_clk), .in_pin(in_pin));
  // Prints the counts and the verdict, then stops.
  task automatic finish_test;
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : finish_test
  // One bus access, held until waitrequest is seen low at a rising edge.
  task automatic bus(input logic w, input logic [7:0] a, input logic [15:0] d,
    output logic [15:0] q);
    @(posedge sys_clk);
    avs_address <= a;
    avs_writedata <= {16'h0000, d};
    avs_write <= w;
    avs_read <= !w;
    do
    begin
      @(posedge sys_clk);
    end
    while (avs_waitrequest !== 1'b0);
    q = avs_readdata[15:0];
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask : bus
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    bus(1'b1, a, d, rd);
  endtask : wr
  task automatic rdc(input logic [7:0] a, input logic [15:0] e);
    bus(1'b0, a, 16'h0000, rd);
    `CHECK(rd, e)
  endtask : rdc
  // Counts edges until the chosen interrupt is seen; the watchdog ends a hang.
  task automatic wait_irq(input int idx, output int c);
    c = 0;
    do
    begin
      @(posedge sys_clk);
      c++;
    end
    while (timer_irq[idx] !== 1'b1);
  endtask : wait_irq
  // Resets the unit and idles the pins.
  task automatic do_reset;
    @(posedge sys_clk);
    rst <= 1'b1;
    u_pins.set(0, 1'b0);
    u_pins.set(1, 1'b0);
    repeat (16) @(posedge sys_clk);
    rst <= 1'b0;
  endtask : do_reset
  task automatic t_regs;
    do_reset();
    rdc(tmu_pkg::T0_CTRL_IDX, 16'h0000);
    wr(tmu_pkg::T0_CTRL_IDX, 16'h8001);
    rdc(tmu_pkg::T0_CTRL_IDX, 16'h0001);
    wr(tmu_pkg::T0_CTRL_IDX, 16'hc000);
    rdc(tmu_pkg::T0_CTRL_IDX, 16'h8000);
    rdc(8'h70, 16'h0000);
    wr(tmu_pkg::T2_CTRL_IDX, 16'hffff);
    rdc(tmu_pkg::T2_CTRL_IDX, 16'ha021);
    $display("t_regs done");
  endtask : t_regs
  task automatic t_single;
    do_reset();
    u_pins.set(0, 1'b1);
    wr(tmu_pkg::T0_CMPA_IDX, 16'h0003);
    wr(tmu_pkg::T0_CTRL_IDX, 16'he001);
    wait_irq(0, n);
    wait_irq(0, n);
    `CHECK(n, 16)
    `CHECK(out_pin[0], 1'b0)
    rdc(tmu_pkg::T0_CTRL_IDX, 16'ha021);
    $display("t_single done");
  endtask : t_single
  task automatic t_halt;
    do_reset();
    u_pins.set(0, 1'b1);
    wr(tmu_pkg::T0_CMPA_IDX, 16'h0002);
    wr(tmu_pkg::T0_CTRL_IDX, 16'hc000);
    repeat (60) @(posedge sys_clk);
    rdc(tmu_pkg::T0_CTRL_IDX, 16'h0020);
    rdc(tmu_pkg::T0_COUNT_IDX, 16'h0000);
    $display("t_halt done");
  endtask : t_halt
  task automatic t_dual;
    do_reset();
    u_pins.set(0, 1'b1);
    wr(tmu_pkg::T0_CMPA_IDX, 16'h0001);
    wr(tmu_pkg::T0_CMPB_IDX, 16'h0002);
    wr(tmu_pkg::T0_CTRL_IDX, 16'he003);
    wait_irq(0, n);
    rdc(tmu_pkg::T0_CTRL_IDX, 16'hb023);
    `CHECK(out_pin[0], 1'b0)
    wait_irq(0, n);
    wait_irq(0, n);
    `CHECK(n, 8)
    wait_irq(0, n);
    `CHECK(n, 12)
    $display("t_dual done");
  endtask : t_dual
  task automatic t_gate;
    do_reset();
    wr(tmu_pkg::T0_CMPA_IDX, 16'hffff);
    wr(tmu_pkg::T0_CTRL_IDX, 16'hc001);
    repeat (40) @(posedge sys_clk);
    rdc(tmu_pkg::T0_COUNT_IDX, 16'h0000);
    u_pins.set(0, 1'b1);
    repeat (40) @(posedge sys_clk);
    bus(1'b0, tmu_pkg::T0_COUNT_IDX, 16'h0000, rd);
    `CHECK(rd > 16'h0004, 1'b1)
    wr(tmu_pkg::T0_CTRL_IDX, 16'hc011);
    u_pins.pulses(0, 1);
    bus(1'b0, tmu_pkg::T0_COUNT_IDX, 16'h0000, rd);
    `CHECK(rd < 16'h0004, 1'b1)
    $display("t_gate done");
  endtask : t_gate
  task automatic t_ext;
    do_reset();
    wr(tmu_pkg::T1_CMPA_IDX, 16'h0001);
    wr(tmu_pkg::T1_CTRL_IDX, 16'he015);
    u_pins.pulses(1, 12);
    repeat (8) @(posedge sys_clk);
    rdc(tmu_pkg::T1_COUNT_IDX, 16'h0001);
    rdc(tmu_pkg::T1_CTRL_IDX, 16'ha035);
    $display("t_ext done");
  endtask : t_ext
  task automatic t_pre;
    do_reset();
    u_pins.set(1, 1'b1);
    wr(tmu_pkg::T2_CMPA_IDX, 16'h0001);
    wr(tmu_pkg::DMA_REQ_EN_IDX, 16'h0001);
    wr(tmu_pkg::T1_CMPA_IDX, 16'hffff);
    wr(tmu_pkg::T1_CTRL_IDX, 16'hc009);
    wr(tmu_pkg::T2_CTRL_IDX, 16'he001);
    n = 0;
    n1 = 0;
    n2 = 0;
    repeat (80)
    begin
      @(posedge sys_clk);
      n += int'(dma_timer_request[0] === 1'b1);
      n1 += int'(dma_timer_request[1] !== 1'b0);
      n2 += int'(timer_irq[2] === 1'b1);
    end
    `CHECK(n, 10)
    `CHECK(n1, 0)
    `CHECK(n2, 10)
    bus(1'b0, tmu_pkg::T1_COUNT_IDX, 16'h0000, q1);
    repeat (13) @(posedge sys_clk);
    bus(1'b0, tmu_pkg::T1_COUNT_IDX, 16'h0000, rd);
    `CHECK(rd - q1, 16'h0002)
    $display("t_pre done");
  endtask : t_pre
  // Cuts a hang short.
  initial
  begin
    repeat (20000) @(posedge sys_clk);
    miscompares++;
    finish_test();
  end
  // Runs the scenarios in turn.
  initial
  begin
    t_regs();
    t_single();
    t_halt();
    t_dual();
    t_gate();
    t_ext();
    t_pre();
    finish_test();
  end
endmodule : tmu_top_tb
